//--- hdl/hlc_pkg.sv
// What this block does
// [RULE_01] While overdriving, the boost bit raises the feedback loop gain.
// [RULE_02] The coupling bit switches the input pin common-mode bias on.
// [RULE_03] Software sets the coupling bit only for analog input mode.
// [RULE_04] Resonant mode seeds drive time as field x 0.1 ms + 0.5 ms.
// [RULE_05] Resonant drive time is then adjusted by feedback while running.
// [RULE_06] Software sets the drive-time field near half the resonance period.
// [RULE_07] Eccentric mode samples back-EMF every field x 0.2 ms + 1 ms.
// [RULE_08] First register at 0x1B: boost 7, reserved 6, bias 5, time 4:0.
// [RULE_09] Second register at 0x1C: direction 7 and stabilizer 6, both 1.
// [RULE_10] Unidirectional mode scales input linearly, brakes from feedback.
// [RULE_11] Software uses unidirectional mode only when running closed-loop.
// [RULE_12] Bidirectional open-loop brakes below 50% and drives above 50%.
// [RULE_13] Resonance sampling time is 150, 200, 250 or 300 us, reset 3.
// [RULE_14] The reserved bit ignores writes and reads as zero.
package hlc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL1_ADDR = 8'h1b;
  localparam logic [7:0] CTRL2_ADDR = 8'h1c;
  localparam logic [7:0] CTRL1_RST  = 8'h93;
  localparam logic [3:0] CTRL2_RST  = 4'hf;
  localparam int         BOOST_BIT  = 7;
  localparam int         CM_BIT     = 5;
  localparam int         DT_MSB     = 4;
  localparam int         DIR_BIT    = 7;
  localparam int         STAB_BIT   = 6;
  localparam int         ST_MSB     = 5;
  localparam int         ST_LSB     = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS      = 40;
  localparam int RES_STEP_NS = 100000;
  localparam int RES_BASE_NS = 500000;
  localparam int ECC_STEP_NS = 200000;
  localparam int ECC_BASE_NS = 1000000;
  localparam int ST_BASE_NS  = 150000;
  localparam int ST_STEP_NS  = 50000;
  localparam int ADJ_NS      = 1000;
  localparam int RES_STEP_CYC = (RES_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES_BASE_CYC = (RES_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ECC_STEP_CYC = (ECC_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ECC_BASE_CYC = (ECC_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ST_BASE_CYC  = (ST_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ST_STEP_CYC  = (ST_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADJ_CYC      = (ADJ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 18;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hlc_req_s;

  typedef struct packed {
    logic [7:0] amp;
    logic       pos;
    logic       brake;
  } hlc_drive_s;

endpackage

//--- hdl/hlc_tick_timer.sv
module hlc_tick_timer
  import hlc_pkg::*;
#(
  parameter int W = 18
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Control
  input  wire logic         en,
  input  wire logic [W-1:0] period,
  // Event
  output logic              tick_ff
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         nxt_tick;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (!en) begin
      nxt_cnt = '0;
    end else if (cnt_ff + W'(1) >= period) begin
      nxt_cnt  = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
endmodule // hlc_tick_timer

//--- hdl/hlc_loop_ctrl.sv
module hlc_loop_ctrl
  import hlc_pkg::*;
#(
  parameter int RES_BASE = hlc_pkg::RES_BASE_CYC,
  parameter int ECC_STEP = hlc_pkg::ECC_STEP_CYC,
  parameter int ECC_BASE = hlc_pkg::ECC_BASE_CYC
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                ce,
  // Register port
  input  wire hlc_pkg::hlc_req_s   req,
  output logic [7:0]               reg_rdata_ff,
  // Engine status
  input  wire logic                linear_resonant_mode,
  input  wire logic                closed_loop,
  input  wire logic                overdriving,
  input  wire logic                brake_near_done,
  input  wire logic                fb_brake,
  input  wire logic                res_early,
  input  wire logic                res_late,
  input  wire logic [7:0]          in_level,
  // Controls out
  output logic                     gain_boost_ff,
  output logic                     cm_bias_en_ff,
  output logic                     brake_gain_reduce_ff,
  output logic [hlc_pkg::CNT_W-1:0] drive_cyc_ff,
  output logic                     drive_tick,
  output logic                     res_sample_tick,
  output hlc_pkg::hlc_drive_s      drive_ff
);
  import hlc_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ctrl1_ff;
  logic [3:0] ctrl2_ff;
  logic [7:0] nxt_ctrl1;
  logic [3:0] nxt_ctrl2;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_ctrl1 = ctrl1_ff;
    nxt_ctrl2 = ctrl2_ff;
    nxt_rdata = reg_rdata_ff;
    if (req.wr && req.addr == CTRL1_ADDR) begin // RULE_08
      nxt_ctrl1 = req.wdata & 8'hbf; // RULE_14
    end
    if (req.wr && req.addr == CTRL2_ADDR) begin // RULE_09
      nxt_ctrl2 = req.wdata[7:4];
    end
    if (req.rd) begin
      unique case (req.addr)
        CTRL1_ADDR: nxt_rdata = ctrl1_ff & 8'hbf; // RULE_14
        CTRL2_ADDR: nxt_rdata = {ctrl2_ff, 4'h0};
        default:    nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_ff     <= CTRL1_RST; // RULE_01
      ctrl2_ff     <= CTRL2_RST; // RULE_09
      reg_rdata_ff <= 8'h00;
    end else if (ce) begin
      ctrl1_ff     <= nxt_ctrl1;
      ctrl2_ff     <= nxt_ctrl2;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Loop gain and bias controls
  // ****************************************
  logic nxt_boost;
  logic nxt_cm;
  logic nxt_stab;

  always_comb begin
    nxt_boost = ctrl1_ff[BOOST_BIT] & overdriving; // RULE_01
    nxt_cm    = ctrl1_ff[CM_BIT]; // RULE_02
    nxt_stab  = ctrl2_ff[STAB_BIT-4] & brake_near_done;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gain_boost_ff        <= 1'b0;
      cm_bias_en_ff        <= 1'b0;
      brake_gain_reduce_ff <= 1'b0;
    end else if (ce) begin
      gain_boost_ff        <= nxt_boost;
      cm_bias_en_ff        <= nxt_cm;
      brake_gain_reduce_ff <= nxt_stab;
    end
  end

  // ****************************************
  // Drive time
  // ****************************************
  logic [CNT_W-1:0] seed_cyc;
  logic [CNT_W-1:0] nxt_drive_cyc;
  logic [CNT_W-1:0] st_cyc;
  logic [4:0]       dt_field;
  logic             reseed;

  assign dt_field = ctrl1_ff[DT_MSB:0];
  assign reseed   = (req.wr && req.addr == CTRL1_ADDR)
                    || !linear_resonant_mode;

  always_comb begin
    if (linear_resonant_mode) begin
      seed_cyc = CNT_W'(int'(nxt_ctrl1[DT_MSB:0]) * RES_STEP_CYC
                        + RES_BASE); // RULE_04
    end else begin
      seed_cyc = CNT_W'(int'(dt_field) * ECC_STEP + ECC_BASE); // RULE_07
    end
    st_cyc = CNT_W'(int'(ctrl2_ff[ST_MSB-4:ST_LSB-4]) * ST_STEP_CYC
                    + ST_BASE_CYC); // RULE_13
    nxt_drive_cyc = drive_cyc_ff;
    if (reseed) begin
      nxt_drive_cyc = seed_cyc;
    end else if (res_early && !res_late
                 && drive_cyc_ff > CNT_W'(2 * ADJ_CYC)) begin
      nxt_drive_cyc = drive_cyc_ff - CNT_W'(ADJ_CYC); // RULE_05
    end else if (res_late && !res_early
                 && drive_cyc_ff < {CNT_W{1'b1}} - CNT_W'(ADJ_CYC)) begin
      nxt_drive_cyc = drive_cyc_ff + CNT_W'(ADJ_CYC); // RULE_05
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drive_cyc_ff <= CNT_W'(int'(CTRL1_RST[DT_MSB:0]) * RES_STEP_CYC
                             + RES_BASE);
    end else if (ce) begin
      drive_cyc_ff <= nxt_drive_cyc;
    end
  end

  hlc_tick_timer #(.W(CNT_W)) u_drive_timer (
    .mclk   (mclk),
    .nrst   (nrst),
    .ce     (ce),
    .en     (1'b1),
    .period (drive_cyc_ff),
    .tick_ff(drive_tick)
  );

  hlc_tick_timer #(.W(CNT_W)) u_sample_timer (
    .mclk   (mclk),
    .nrst   (nrst),
    .ce     (ce),
    .en     (linear_resonant_mode),
    .period (st_cyc),
    .tick_ff(res_sample_tick)
  );

  // ****************************************
  // Input level mapping
  // ****************************************
  hlc_drive_s nxt_drive;
  logic [7:0] inv_level;

  always_comb begin
    inv_level = ~in_level;
    nxt_drive = '0;
    if (!ctrl2_ff[DIR_BIT-4]) begin
      nxt_drive.amp   = in_level; // RULE_10
      nxt_drive.pos   = 1'b1;
      nxt_drive.brake = fb_brake; // RULE_10
    end else if (!closed_loop) begin
      if (in_level[7]) begin
        nxt_drive.amp = {in_level[6:0], in_level[6]}; // RULE_12
        nxt_drive.pos = 1'b1;
      end else begin
        nxt_drive.amp   = {inv_level[6:0], inv_level[6]}; // RULE_12
        nxt_drive.brake = 1'b1; // RULE_12
      end
    end else begin
      nxt_drive.brake = fb_brake;
      if (in_level[7]) begin
        nxt_drive.amp = {in_level[6:0], in_level[6]};
        nxt_drive.pos = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drive_ff <= '0;
    end else if (ce) begin
      drive_ff <= nxt_drive;
    end
  end
endmodule // hlc_loop_ctrl

//--- dv/hlc_loop_ctrl_sva.sv
module hlc_loop_ctrl_sva
  import hlc_pkg::*;
(
  // Clock and reset
  input wire logic                mclk,
  input wire logic                nrst,
  input wire logic                ce,
  // Observed
  input wire hlc_pkg::hlc_req_s   req,
  input wire logic [7:0]          reg_rdata_ff,
  input wire logic                overdriving,
  input wire logic                brake_near_done,
  input wire logic                closed_loop,
  input wire logic                fb_brake,
  input wire logic [7:0]          in_level,
  input wire logic                gain_boost_ff,
  input wire logic                cm_bias_en_ff,
  input wire logic                brake_gain_reduce_ff,
  input wire hlc_pkg::hlc_drive_s drive_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_rsv;
    req.rd && ce && req.addr == CTRL1_ADDR |=> !reg_rdata_ff[6];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_unmap;
    req.rd && ce && req.addr != CTRL1_ADDR && req.addr != CTRL2_ADDR
      |=> reg_rdata_ff == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_low;
    req.rd && ce && req.addr == CTRL2_ADDR |=> reg_rdata_ff[3:0] == 4'h0;
  endproperty
  a_low: assert property (p_low) else $error("low nibble set");
  property p_cm;
    req.wr && ce && req.addr == CTRL1_ADDR
      |=> ##1 cm_bias_en_ff == $past(req.wdata[CM_BIT], 2);
  endproperty
  a_cm: assert property (p_cm) else $error("bias enable wrong");
  property p_boost;
    gain_boost_ff |-> $past(overdriving);
  endproperty
  a_boost: assert property (p_boost) else $error("stray boost");
  property p_stab;
    brake_gain_reduce_ff |-> $past(brake_near_done);
  endproperty
  a_stab: assert property (p_stab) else $error("stabilizer early");
  property p_brk;
    drive_ff.brake && !$past(fb_brake)
      |-> $past(in_level) < 8'h80 && !$past(closed_loop);
  endproperty
  a_brk: assert property (p_brk) else $error("brake unexpected");
  property p_pos;
    drive_ff.amp != 8'h00 && !drive_ff.brake |-> drive_ff.pos;
  endproperty
  a_pos: assert property (p_pos) else $error("negative drive");
endmodule // hlc_loop_ctrl_sva

//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import hlc_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, ce = 1'b1, closed_loop = 1'b0;
  logic linear_resonant_mode = 1'b0, overdriving = 1'b0, fb_brake = 1'b0;
  logic brake_near_done = 1'b0, res_early = 1'b0, res_late = 1'b0;
  logic [7:0] in_level = 8'h80;
  hlc_req_s req = '0;
  logic [7:0] reg_rdata_ff;
  logic gain_boost_ff, cm_bias_en_ff, brake_gain_reduce_ff;
  logic drive_tick, res_sample_tick;
  logic [CNT_W-1:0] drive_cyc_ff;
  hlc_drive_s drive_ff;
  int bad_count = 0, cmp_count = 0;
  always #20 mclk = ~mclk;
  hlc_loop_ctrl #(
    .RES_BASE(50),
    .ECC_STEP(20),
    .ECC_BASE(100)
  ) i_dut (
    .mclk                (mclk),
    .nrst                (nrst),
    .ce                  (ce),
    .req                 (req),
    .reg_rdata_ff        (reg_rdata_ff),
    .linear_resonant_mode(linear_resonant_mode),
    .closed_loop         (closed_loop),
    .overdriving         (overdriving),
    .brake_near_done     (brake_near_done),
    .fb_brake            (fb_brake),
    .res_early           (res_early),
    .res_late            (res_late),
    .in_level            (in_level),
    .gain_boost_ff       (gain_boost_ff),
    .cm_bias_en_ff       (cm_bias_en_ff),
    .brake_gain_reduce_ff(brake_gain_reduce_ff),
    .drive_cyc_ff        (drive_cyc_ff),
    .drive_tick          (drive_tick),
    .res_sample_tick     (res_sample_tick),
    .drive_ff            (drive_ff)
  );
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    req = '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    req = '0;
    chk(reg_rdata_ff, exp);
  endtask
  task gap(input bit s, input int exp);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        cyc(1);
        n++;
      end while ((s ? res_sample_tick : drive_tick) !== 1'b1 && n < 9000);
    end
    chk(n, exp);
  endtask
  task drv(input logic [7:0] l, input logic [7:0] a, input logic p, b);
    in_level = l;
    cyc(2);
    chk(drive_ff, {a, p, b});
  endtask
  task t_regs;
    rd(CTRL1_ADDR, 8'h93);
    rd(CTRL2_ADDR, 8'hf0);
    rd(8'h55, 8'h00);
    wr(CTRL1_ADDR, 8'hff);
    rd(CTRL1_ADDR, 8'hbf);
    chk(cm_bias_en_ff, 1'b1);
    wr(CTRL1_ADDR, 8'h13);
    cyc(1);
    chk(cm_bias_en_ff, 1'b0);
  endtask
  task t_ctrl;
    overdriving = 1'b1;
    brake_near_done = 1'b1;
    cyc(2);
    chk(gain_boost_ff, 1'b0);
    wr(CTRL1_ADDR, 8'h93);
    cyc(1);
    chk(gain_boost_ff, 1'b1);
    chk(brake_gain_reduce_ff, 1'b1);
    overdriving = 1'b0;
    cyc(2);
    chk(gain_boost_ff, 1'b0);
    wr(CTRL2_ADDR, 8'hb0);
    cyc(1);
    chk(brake_gain_reduce_ff, 1'b0);
    wr(CTRL2_ADDR, 8'hf0);
    ce = 1'b0;
    wr(CTRL1_ADDR, 8'h20);
    ce = 1'b1;
    rd(CTRL1_ADDR, 8'h93);
  endtask
  task t_drive;
    drv(8'h00, 8'hff, 1'b0, 1'b1);
    drv(8'h40, 8'h7e, 1'b0, 1'b1);
    drv(8'h80, 8'h00, 1'b1, 1'b0);
    drv(8'hc0, 8'h81, 1'b1, 1'b0);
    drv(8'hff, 8'hff, 1'b1, 1'b0);
    closed_loop = 1'b1;
    fb_brake = 1'b1;
    drv(8'h40, 8'h00, 1'b0, 1'b1);
    fb_brake = 1'b0;
    drv(8'hc0, 8'h81, 1'b1, 1'b0);
    wr(CTRL2_ADDR, 8'h70);
    drv(8'h80, 8'h80, 1'b1, 1'b0);
    fb_brake = 1'b1;
    drv(8'h00, 8'h00, 1'b1, 1'b1);
    fb_brake = 1'b0;
    wr(CTRL2_ADDR, 8'hf0);
    closed_loop = 1'b0;
  endtask
  task t_time;
    linear_resonant_mode = 1'b1;
    wr(CTRL1_ADDR, 8'h03);
    chk(drive_cyc_ff, 3 * RES_STEP_CYC + 50);
    res_late = 1'b1;
    cyc(1);
    res_late = 1'b0;
    cyc(1);
    chk(drive_cyc_ff, 3 * RES_STEP_CYC + 75);
    res_early = 1'b1;
    cyc(1);
    res_early = 1'b0;
    cyc(1);
    chk(drive_cyc_ff, 3 * RES_STEP_CYC + 50);
    linear_resonant_mode = 1'b0;
    cyc(2);
    chk(drive_cyc_ff, 3 * 20 + 100);
    gap(1'b0, 160);
    linear_resonant_mode = 1'b1;
    wr(CTRL2_ADDR, 8'hc0);
    gap(1'b1, ST_BASE_CYC);
    wr(CTRL2_ADDR, 8'hf0);
    gap(1'b1, ST_BASE_CYC + 3 * ST_STEP_CYC);
  endtask
  task t_rst;
    wr(CTRL1_ADDR, 8'h20);
    nrst = 1'b0;
    cyc(1);
    chk(cm_bias_en_ff, 1'b0);
    chk(drive_cyc_ff, 19 * RES_STEP_CYC + 50);
    nrst = 1'b1;
    rd(CTRL1_ADDR, 8'h93);
    rd(CTRL2_ADDR, 8'hf0);
    chk(drive_cyc_ff, 19 * RES_STEP_CYC + 50);
  endtask
  task test_done;
    $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2400000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1 nrst = 1'b1;
    t_regs;
    t_ctrl;
    t_drive;
    t_time;
    t_rst;
    test_done;
  end
endmodule // testbench
bind hlc_loop_ctrl hlc_loop_ctrl_sva i_sva (
  .mclk                (mclk),
  .nrst                (nrst),
  .ce                  (ce),
  .req                 (req),
  .reg_rdata_ff        (reg_rdata_ff),
  .overdriving         (overdriving),
  .brake_near_done     (brake_near_done),
  .closed_loop         (closed_loop),
  .fb_brake            (fb_brake),
  .in_level            (in_level),
  .gain_boost_ff       (gain_boost_ff),
  .cm_bias_en_ff       (cm_bias_en_ff),
  .brake_gain_reduce_ff(brake_gain_reduce_ff),
  .drive_ff            (drive_ff)
);
